// >>> design/cht_transfer_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cht_transfer_regs (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // card reply from the command engine
  input  wire logic          resp_load,
  input  wire logic [127:0]  resp_words,
  // receive path from the deserializer
  input  wire logic          rx_load,
  input  wire logic [31:0]   rx_word,
  // transmit path to the serializer
  output logic      [31:0]   tx_word,
  output logic               tx_valid,
  input  wire logic          tx_taken,
  // transfer setup to the data engine
  output logic               xfer_start,
  output logic               xfer_stop,
  output logic      [2:0]    xfer_kind,
  output logic      [16:0]   xfer_count,
  output logic               xfer_unlimited,
  output logic               xfer_use_blen,
  output logic      [15:0]   block_len,
  output logic               dma_byte_mode,
  output logic               io_suspend,
  output logic               io_resume
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic is_resp(input logic [7:0] a);
    is_resp = (a >= cht_pkg::OFS_RESP0) && (a <= cht_pkg::OFS_RESP3)
              && (a[1:0] == 2'h0);
  endfunction

  logic wr_setup, wr_cmd, wr_size, wr_tx, rd_resp, rd_rx;
  assign wr_setup = reg_wr && reg_addr == cht_pkg::OFS_SETUP;
  assign wr_cmd   = reg_wr && reg_addr == cht_pkg::OFS_CMD;
  assign wr_size  = reg_wr && reg_addr == cht_pkg::OFS_SIZE;
  assign wr_tx    = reg_wr && reg_addr == cht_pkg::OFS_TX;
  assign rd_resp  = reg_rd && is_resp(reg_addr);
  assign rd_rx    = reg_rd && reg_addr == cht_pkg::OFS_RX;

  // command word fields, live only during the write
  cht_pkg::cht_kind_e cmd_kind;
  cht_pkg::cht_spop_e cmd_spop;
  logic [1:0]         cmd_tcmd;
  logic [1:0]         cmd_rtyp;
  assign cmd_kind = cht_pkg::cht_kind_e'(reg_wdata[cht_pkg::KIND_LSB +: 3]);
  assign cmd_spop = cht_pkg::cht_spop_e'(reg_wdata[cht_pkg::SPOP_LSB +: 2]);
  assign cmd_tcmd = reg_wdata[cht_pkg::TCMD_LSB +: 2];
  assign cmd_rtyp = reg_wdata[cht_pkg::RTYP_LSB +: 2];

  // ------------------------------------------------------------
  // setup storage
  // ------------------------------------------------------------
  logic [15:0] count_r;
  logic [15:0] blen_r;
  logic        byte_en_r;
  logic [2:0]  resp_len_r;

  // single block size store fed from both registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blen_r <= cht_pkg::BLEN_RST;
    end else if (wr_size) begin
      blen_r <= reg_wdata[cht_pkg::BLEN_LSB +: 16];
    end else if (wr_setup) begin
      blen_r <= reg_wdata[cht_pkg::BLEN_LSB +: 16];
    end
  end

  // count kept whole; top bits left to software in io modes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= cht_pkg::COUNT_RST;
    end else if (wr_size) begin
      count_r <= reg_wdata[15:0];
    end
  end

  // byte-granular dma switch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_en_r <= 1'b0;
    end else if (wr_setup) begin
      byte_en_r <= reg_wdata[cht_pkg::BYTEEN_BIT];
    end
  end

  // reply length set by each command; none reads as one word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resp_len_r <= cht_pkg::RESP_SHORT;
    end else if (wr_cmd) begin
      resp_len_r <= (cmd_rtyp == cht_pkg::RTYP_136) ?
                    cht_pkg::RESP_LONG : cht_pkg::RESP_SHORT;
    end
  end

  // ------------------------------------------------------------
  // size decode
  // ------------------------------------------------------------
  cht_dec_if dif ();
  assign dif.kind  = cmd_kind;
  assign dif.count = count_r;

  cht_size_dec u_dec (
    .d (dif.dec)
  );

  // ------------------------------------------------------------
  // transfer launch
  // ------------------------------------------------------------
  logic        start_r, stop_r, susp_r, resm_r;
  logic [2:0]  kind_r;
  logic [16:0] eff_r;
  logic        unl_r, useb_r, cnt_bad_r;

  // start pulse only for a real kind, so reserved codes stay idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_r <= 1'b0;
      stop_r  <= 1'b0;
    end else begin
      start_r <= wr_cmd && cmd_tcmd == cht_pkg::TCMD_START
                 && dif.kind_ok;
      stop_r  <= wr_cmd && cmd_tcmd == cht_pkg::TCMD_STOP;
    end
  end

  // sizing held until the next launch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kind_r    <= 3'h0;
      eff_r     <= 17'h00000;
      unl_r     <= 1'b0;
      useb_r    <= 1'b1;
      cnt_bad_r <= 1'b0;
    end else if (wr_cmd && cmd_tcmd == cht_pkg::TCMD_START
                 && dif.kind_ok) begin
      kind_r    <= cmd_kind;
      eff_r     <= dif.eff_count;
      unl_r     <= dif.unlimited;
      useb_r    <= dif.uses_blen;
      cnt_bad_r <= !dif.count_ok;
    end
  end

  // special ops are one-cycle pulses; reserved code gives neither
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      susp_r <= 1'b0;
      resm_r <= 1'b0;
    end else begin
      susp_r <= wr_cmd && cmd_spop == cht_pkg::SPOP_SUSPEND;
      resm_r <= wr_cmd && cmd_spop == cht_pkg::SPOP_RESUME;
    end
  end

  // ------------------------------------------------------------
  // reply words
  // ------------------------------------------------------------
  logic [31:0] resp_word;
  logic [1:0]  resp_ptr;

  cht_resp_store #(
    .WORDS (4)
  ) u_resp (
    .clk     (clk),
    .resetn  (resetn),
    .load    (resp_load),
    .words   (resp_words),
    .restart (wr_cmd),
    .nwords  (resp_len_r),
    .rd      (rd_resp),
    .rd_word (resp_word),
    .ptr     (resp_ptr)
  );

  // ------------------------------------------------------------
  // data words
  // ------------------------------------------------------------
  logic [31:0] rx_r, tx_r;
  logic        rx_rdy_r, tx_vld_r;

  // in byte mode only the low lane is real data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_r <= 32'h0000_0000;
    end else if (rx_load) begin
      rx_r <= byte_en_r ? {24'h000000, rx_word[7:0]} : rx_word;
    end
  end

  // new word beats a read in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_rdy_r <= 1'b0;
    end else if (rx_load) begin
      rx_rdy_r <= 1'b1;
    end else if (rd_rx) begin
      rx_rdy_r <= 1'b0;
    end
  end

  // a write over an untaken word replaces it; no queue here
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_r <= 32'h0000_0000;
    end else if (wr_tx) begin
      tx_r <= byte_en_r ? {24'h000000, reg_wdata[7:0]} : reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_vld_r <= 1'b0;
    end else if (wr_tx) begin
      tx_vld_r <= 1'b1;
    end else if (tx_taken) begin
      tx_vld_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // transmit word and unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_addr == cht_pkg::OFS_SETUP) begin
      rdata_nxt = {blen_r, 2'h0, byte_en_r, 13'h0000};
    end else if (reg_addr == cht_pkg::OFS_SIZE) begin
      rdata_nxt = {blen_r, count_r};
    end else if (is_resp(reg_addr)) begin
      rdata_nxt = resp_word;
    end else if (reg_addr == cht_pkg::OFS_RX) begin
      rdata_nxt = rx_r;
    end else if (reg_addr == cht_pkg::OFS_STAT) begin
      rdata_nxt = {26'h0000000, resp_ptr, cnt_bad_r, 1'b0,
                   !tx_vld_r, rx_rdy_r};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata      = rdata_r;
  assign tx_word        = tx_r;
  assign tx_valid       = tx_vld_r;
  assign xfer_start     = start_r;
  assign xfer_stop      = stop_r;
  assign xfer_kind      = kind_r;
  assign xfer_count     = eff_r;
  assign xfer_unlimited = unl_r;
  assign xfer_use_blen  = useb_r;
  assign block_len      = blen_r;
  assign dma_byte_mode  = byte_en_r;
  assign io_suspend     = susp_r;
  assign io_resume      = resm_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic start_cmd;
  assign start_cmd = wr_cmd && cmd_tcmd == cht_pkg::TCMD_START;

  a_kind_launch: assert property (
    start_cmd && cmd_kind == cht_pkg::KIND_MULTI
    |=> xfer_start && xfer_kind == 3'h1)
    else $error("multi block launch not seen");
  a_rsv_idle: assert property (
    start_cmd && (cmd_kind == cht_pkg::KIND_RSV3
    || cmd_kind == cht_pkg::KIND_RSV7) |=> !xfer_start)
    else $error("reserved kind started a transfer");
  a_spop_pulse: assert property (
    wr_cmd && cmd_spop == cht_pkg::SPOP_RESUME
    |=> io_resume && !io_suspend ##1 (!io_resume || $past(wr_cmd)))
    else $error("resume pulse wrong");
  a_count_field: assert property (
    wr_size ##1 reg_rd && reg_addr == cht_pkg::OFS_SIZE
    |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
    else $error("count readback wrong");
  a_multi_zero: assert property (
    start_cmd && cmd_kind == cht_pkg::KIND_MULTI && count_r == 16'h0000
    |=> xfer_unlimited && xfer_count == 17'h00000)
    else $error("zero multi count not unlimited");
  a_iobyte_zero: assert property (
    start_cmd && cmd_kind == cht_pkg::KIND_IO_BYTE && count_r == 16'h0000
    |=> xfer_count == 17'h00200 && !xfer_unlimited)
    else $error("zero byte count not 512");
  a_ioblk_count: assert property (
    start_cmd && cmd_kind == cht_pkg::KIND_IO_BLOCK && count_r == 16'h01FF
    |=> xfer_count == 17'h001FF && !xfer_unlimited)
    else $error("io block count wrong");
  a_blen_shared: assert property (
    wr_setup && !wr_size |=> block_len == $past(reg_wdata[31:16]))
    else $error("block size not shared");
  a_blen_ignored: assert property (
    start_cmd && cmd_kind == cht_pkg::KIND_IO_BYTE |=> !xfer_use_blen)
    else $error("byte mode uses block size");
  a_byte_lane: assert property (
    wr_tx && dma_byte_mode |=> tx_word[31:8] == 24'h000000 && tx_valid)
    else $error("byte mode word not narrowed");
  a_rx_read: assert property (
    rd_rx && !rx_load |=> reg_rdata == $past(rx_r)
    ##1 (reg_rdata == 32'h0 || $past(reg_rd)))
    else $error("receive word read wrong");

  c_multi_go: cover property (start_cmd && cmd_kind == cht_pkg::KIND_MULTI);
  c_long_reply: cover property (rd_resp && resp_len_r == 3'h4
                                && resp_ptr == 2'h3);
  c_tx_hand: cover property (wr_tx ##1 tx_taken);
  c_rx_race: cover property (rd_rx && rx_load);
endmodule
`default_nettype wire

// >>> shared/cht_pkg.sv
`default_nettype none
package cht_pkg;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_SETUP = 8'h04;
  localparam logic [7:0] OFS_CMD   = 8'h14;
  localparam logic [7:0] OFS_SIZE  = 8'h18;
  localparam logic [7:0] OFS_RESP0 = 8'h20;
  localparam logic [7:0] OFS_RESP3 = 8'h2C;
  localparam logic [7:0] OFS_RX    = 8'h30;
  localparam logic [7:0] OFS_TX    = 8'h34;
  localparam logic [7:0] OFS_STAT  = 8'h40;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int RTYP_LSB   = 6;
  localparam int BYTEEN_BIT = 13;
  localparam int TCMD_LSB   = 16;
  localparam int KIND_LSB   = 19;
  localparam int SPOP_LSB   = 24;
  localparam int BLEN_LSB   = 16;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [15:0] BLEN_RST   = 16'h0000;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [1:0]  TCMD_START = 2'h1;
  localparam logic [1:0]  TCMD_STOP  = 2'h2;
  localparam logic [1:0]  RTYP_48    = 2'h1;
  localparam logic [1:0]  RTYP_136   = 2'h2;
  localparam logic [2:0]  RESP_SHORT = 3'h1;
  localparam logic [2:0]  RESP_LONG  = 3'h4;
  localparam logic [16:0] IO_BYTE_ZERO = 17'h00200;
  localparam logic [15:0] IO_CNT_LIM   = 16'h0200;
  typedef enum logic [2:0] {
    KIND_SINGLE, KIND_MULTI, KIND_STREAM, KIND_RSV3,
    KIND_IO_BYTE, KIND_IO_BLOCK, KIND_RSV6, KIND_RSV7
  } cht_kind_e;
  typedef enum logic [1:0] {
    SPOP_NONE, SPOP_SUSPEND, SPOP_RESUME, SPOP_RSV
  } cht_spop_e;
endpackage
`default_nettype wire

// >>> shared/cht_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
// transfer setup handed to the size decoder and its verdict back
interface cht_dec_if;
  cht_pkg::cht_kind_e kind;
  logic [15:0]        count;
  logic [16:0]        eff_count;
  logic               unlimited;
  logic               uses_blen;
  logic               kind_ok;
  logic               count_ok;
  modport dec (input kind, count,
               output eff_count, unlimited, uses_blen, kind_ok, count_ok);
  modport top (output kind, count,
               input eff_count, unlimited, uses_blen, kind_ok, count_ok);
endinterface
`default_nettype wire

// >>> design/cht_size_dec.sv
`timescale 1ns/1ps
`default_nettype none
module cht_size_dec (
  // setup in, verdict out
  cht_dec_if.dec d
);
  // ------------------------------------------------------------
  // transfer kind to effective size
  // ------------------------------------------------------------
  // pure decode; the top samples it on the command write
  always_comb begin
    d.eff_count = {1'b0, d.count};
    d.unlimited = 1'b0;
    d.uses_blen = 1'b1;
    d.kind_ok   = 1'b1;
    d.count_ok  = 1'b1;
    case (d.kind)
      cht_pkg::KIND_SINGLE: begin
        d.eff_count = 17'h00001;
      end
      cht_pkg::KIND_MULTI: begin
        d.unlimited = (d.count == 16'h0000);
      end
      cht_pkg::KIND_STREAM: begin
        d.eff_count = 17'h00000;
        d.unlimited = 1'b1;
        d.uses_blen = 1'b0;
      end
      cht_pkg::KIND_IO_BYTE: begin
        d.uses_blen = 1'b0;
        d.count_ok  = (d.count < cht_pkg::IO_CNT_LIM);
        if (d.count == 16'h0000) begin
          d.eff_count = cht_pkg::IO_BYTE_ZERO;
        end
      end
      cht_pkg::KIND_IO_BLOCK: begin
        d.unlimited = (d.count == 16'h0000);
        d.count_ok  = (d.count < cht_pkg::IO_CNT_LIM);
      end
      default: begin
        d.eff_count = 17'h00000;
        d.kind_ok   = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> design/cht_resp_store.sv
`timescale 1ns/1ps
`default_nettype none
module cht_resp_store #(
  parameter int WORDS = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // card side
  input  wire logic             load,
  input  wire logic [127:0]     words,
  // software side
  input  wire logic             restart,
  input  wire logic [2:0]       nwords,
  input  wire logic             rd,
  output logic      [31:0]      rd_word,
  output logic      [1:0]       ptr
);
  logic [31:0] mem_r [WORDS];
  logic [1:0]  ptr_r;
  logic [1:0]  ptr_nxt;

  // ------------------------------------------------------------
  // word storage
  // ------------------------------------------------------------
  // word 0, the low 32 bits of the reply, goes out first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < WORDS; i++) mem_r[i] <= 32'h0000_0000;
    end else if (load) begin
      for (int i = 0; i < WORDS; i++) mem_r[i] <= words[32*i +: 32];
    end
  end

  // each read steps on, wrapping after the reply length
  assign ptr_nxt = ({1'b0, ptr_r} + 3'h1 >= nwords) ? 2'h0 : ptr_r + 2'h1;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr_r <= 2'h0;
    end else if (restart || load) begin
      ptr_r <= 2'h0;
    end else if (rd) begin
      ptr_r <= ptr_nxt;
    end
  end

  assign rd_word = mem_r[ptr_r];
  assign ptr     = ptr_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_resp_step: assert property (@(posedge clk) disable iff (!resetn)
    rd && !restart && !load && nwords == 3'h4 |=> ptr_r == $past(ptr_r) + 2'h1)
    else $error("reply index did not step on read");
  a_resp_short: assert property (@(posedge clk) disable iff (!resetn)
    rd && !restart && !load && nwords == 3'h1 |=> ptr_r == 2'h0)
    else $error("short reply index moved");
endmodule
`default_nettype wire

// >>> tb/cht_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far side: command engine, deserializer and serializer
// ----------------------------------------------------------------
module cht_card_model (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // serializer pace
  input  wire logic          slow,
  // reply and receive words
  output logic               resp_load,
  output logic [127:0]       resp_words,
  output logic               rx_load,
  output logic [31:0]        rx_word,
  // transmit handshake
  input  wire logic          tx_valid,
  output logic               tx_taken
);
  int waited;
  initial begin
    resp_load  = 1'b0;
    resp_words = '0;
    rx_load    = 1'b0;
    rx_word    = '0;
  end
  // reply words, inverted once released so stale values never match
  task automatic send_reply(input logic [127:0] w);
    @(posedge clk);
    resp_words <= w;
    resp_load  <= 1'b1;
    @(posedge clk);
    resp_load  <= 1'b0;
    resp_words <= ~w;
  endtask
  // one received word from the card
  task automatic push_rx(input logic [31:0] w);
    @(posedge clk);
    rx_word <= w;
    rx_load <= 1'b1;
    @(posedge clk);
    rx_load <= 1'b0;
    rx_word <= ~w;
  endtask
  // serializer takes a word on the first edge it sees it; slow mode stalls 6 cycles
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_taken <= 1'b0;
      waited   <= 0;
    end else begin
      tx_taken <= 1'b0;
      if (tx_valid === 1'b1 && !tx_taken) begin
        if (waited >= (slow ? 6 : 0)) begin
          tx_taken <= 1'b1;
          waited   <= 0;
        end else begin
          waited <= waited + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_cht_transfer_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_cht_transfer_regs;
  logic         clk, resetn, reg_wr, reg_rd, slow;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, rx_word, tx_word, d;
  logic [127:0] resp_words;
  logic         resp_load, rx_load, tx_valid, tx_taken;
  logic         xfer_start, xfer_stop, xfer_unlimited, xfer_use_blen;
  logic         dma_byte_mode, io_suspend, io_resume;
  logic [2:0]   xfer_kind;
  logic [16:0]  xfer_count;
  logic [15:0]  block_len;
  int           mismatches, tests_run;
  // ----------------------------------------------------------------
  // block and far side
  // ----------------------------------------------------------------
  cht_transfer_regs dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .resp_load, .resp_words, .rx_load, .rx_word,
    .tx_word, .tx_valid, .tx_taken, .xfer_start, .xfer_stop, .xfer_kind,
    .xfer_count, .xfer_unlimited, .xfer_use_blen, .block_len,
    .dma_byte_mode, .io_suspend, .io_resume);
  cht_card_model card (.clk, .resetn, .slow, .resp_load, .resp_words,
    .rx_load, .rx_word, .tx_valid, .tx_taken);
  // ----------------------------------------------------------------
  // bus tasks and compare
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle write; returns at the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] v,
                       output logic [31:0] r);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clk);
    reg_rd    <= 1'b0;
    #1 r = reg_rdata;
  endtask
  function automatic logic [31:0] cmdw(input int rt, tc, k, op);
    return (rt << cht_pkg::RTYP_LSB) | (tc << cht_pkg::TCMD_LSB) |
           (k << cht_pkg::KIND_LSB) | (op << cht_pkg::SPOP_LSB);
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_size;
    rd(cht_pkg::OFS_SIZE, d);
    chk(d, 32'h0000_0000);
    wr_rd(cht_pkg::OFS_SIZE, 32'h0200_01FF, d);
    chk(d, 32'h0200_01FF);
    chk(32'(block_len), 32'h0000_0200);
    // block size through the setup view, byte dma on
    wr(cht_pkg::OFS_SETUP, 32'h0045_2000);
    rd(cht_pkg::OFS_SIZE, d);
    chk(d, 32'h0045_01FF);
    chk(32'(dma_byte_mode), 32'h0000_0001);
    wr(cht_pkg::OFS_SIZE, 32'h0080_0003);
    rd(cht_pkg::OFS_SETUP, d);
    chk(d & 32'hFFFF_2000, 32'h0080_2000);
  endtask
  // every kind at count zero and at its top legal count
  task automatic t_kinds;
    logic [2:0]  ek;
    logic [16:0] ec;
    logic        eu, eb, st;
    logic [15:0] c;
    ek = 3'h0;
    ec = 17'h00000;
    eu = 1'b0;
    eb = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        c  = (p == 0) ? 16'h0000 : ((k == 1) ? 16'hFFFF : 16'h01FF);
        st = !(k == 3 || k >= 6);
        if (st) begin
          ek = 3'(k);
          ec = (k == 0) ? 17'h1 : (k == 2) ? 17'h0 :
               (k == 4 && c == 0) ? 17'h00200 : {1'b0, c};
          eu = (k == 2) || ((k == 1 || k == 5) && c == 0);
          eb = !(k == 2 || k == 4);
        end
        wr(cht_pkg::OFS_SIZE, {16'h0010, c});
        wr(cht_pkg::OFS_CMD, cmdw(0, 1, k, 0));
        chk({xfer_start, xfer_unlimited, xfer_use_blen, xfer_kind,
             xfer_count}, {st, eu, eb, ek, ec});
        @(posedge clk);
        #1 chk(32'(xfer_start), 32'h0);
      end
    end
  endtask
  task automatic t_ops;
    for (int op = 0; op < 4; op++) begin
      wr(cht_pkg::OFS_CMD, cmdw(0, 0, 0, op));
      chk({io_suspend, io_resume, xfer_start},
          {op == 1, op == 2, 1'b0});
    end
    wr(cht_pkg::OFS_CMD, cmdw(0, 2, 1, 0));
    chk({xfer_stop, xfer_start}, 2'b10);
  endtask
  // long reply walks four words and wraps; short reply repeats word 0
  task automatic t_reply;
    logic [127:0] w;
    w = 128'h4444_0004_3333_0003_2222_0002_1111_0001;
    wr(cht_pkg::OFS_CMD, cmdw(2, 0, 0, 0));
    card.send_reply(w);
    for (int i = 0; i < 5; i++) begin
      rd(8'(cht_pkg::OFS_RESP0 + 4 * (i % 4)), d);
      chk(d, w[32 * (i % 4) +: 32]);
    end
    // status: reply index 1, transmit empty, nothing received
    rd(cht_pkg::OFS_STAT, d);
    chk(d, 32'h0000_0012);
    wr(cht_pkg::OFS_CMD, cmdw(1, 0, 0, 0));
    card.send_reply(~w);
    for (int i = 0; i < 2; i++) begin
      rd(cht_pkg::OFS_RESP0, d);
      chk(d, ~w[31:0]);
    end
  endtask
  task automatic t_rx;
    card.push_rx(32'hA5C3_9E7F);
    rd(cht_pkg::OFS_RX, d);
    chk(d, 32'h0000_007F);
    wr(cht_pkg::OFS_SETUP, 32'h0080_0000);
    card.push_rx(32'hA5C3_9E7F);
    wr(cht_pkg::OFS_RX, 32'h0000_0000);
    rd(cht_pkg::OFS_RX, d);
    chk(d, 32'hA5C3_9E7F);
    rd(cht_pkg::OFS_TX, d);
    chk(d, 32'h0);
    rd(8'h7C, d);
    chk(d, 32'h0);
  endtask
  // transmit word held for a stalling serializer, then byte mode
  task automatic t_tx;
    slow = 1'b1;
    wr(cht_pkg::OFS_TX, 32'hDEAD_BEEF);
    chk({tx_valid, tx_word}, {1'b1, 32'hDEAD_BEEF});
    repeat (3) @(posedge clk);
    #1 chk(32'(tx_valid), 32'h1);
    repeat (20) begin
      @(posedge clk);
      #1 if (tx_valid === 1'b0) break;
    end
    chk(32'(tx_valid), 32'h0);
    slow = 1'b0;
    wr(cht_pkg::OFS_SETUP, 32'h0080_2000);
    wr(cht_pkg::OFS_TX, 32'hDEAD_BEEF);
    chk(tx_word, 32'h0000_00EF);
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // the whole run needs well under 2000 cycles
  initial begin
    #(5 * 5000);
    mismatches++;
    test_done;
  end
  initial begin
    {resetn, reg_wr, reg_rd, slow} = 4'h0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    mismatches = 0;
    tests_run  = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1 chk({xfer_start, xfer_use_blen, tx_valid, block_len}, 19'h20000);
    t_size;
    t_kinds;
    t_ops;
    t_reply;
    t_rx;
    t_tx;
    test_done;
  end
endmodule
`default_nettype wire
